// ===== src/pledb_led_ctrl.v
// Operation
// [RL1] the led source is bits 7-4 and codes 0000 and 0110 drive nothing.
// [RL2] code 1110 shows duplex status with always-stretched collisions.
// [RL3] code 1101 shows link with always-stretched tx and rx activity.
// [RL4] code 1100 shows link with always-stretched rx activity.
// [RL5] codes 1011, 1001 and 1000 give slow blink, off and on.
// [RL6] code 0111 shows tx or rx activity, stretched only when enabled.
// [RL7] code 0101 shows the current duplex status directly.
// [RL8] code 0100 shows the current link status directly.
// [RL9] code 0011 pulses on collisions, stretched only when enabled.
// [RL10] code 0010 pulses on receive, stretched only when enabled.
// [RL11] code 0001 pulses on transmit, stretched only when enabled.
// [RL12] software writes zero into reserved bit 0.
// [RL13] bits 3-2 pick stretch time and bit 1 enables it, resetting to one.
// [RL14] a stretch holds each event a least time and new events restart it.
`timescale 1ns/1ps
`include "pledb_consts.vh"
module pledb_led_ctrl #(
   parameter [31:0] T0_CYC = `PLEDB_CYC(`PLEDB_T0_NS),
   parameter [31:0] T1_CYC = `PLEDB_CYC(`PLEDB_T1_NS),
   parameter [31:0] T2_CYC = `PLEDB_CYC(`PLEDB_T2_NS),
   parameter [31:0] SLOW_CYC = `PLEDB_CYC(`PLEDB_SLOW_NS),
   parameter [31:0] FAST_CYC = `PLEDB_CYC(`PLEDB_FAST_NS)
) (
   input wire clk_sys_i,
   input wire srst_i,
   input wire reg_wr_i,
   input wire [15:0] reg_wdata_i,
   output wire [15:0] reg_rdata_o,
   input wire tx_act_i,
   input wire rx_act_i,
   input wire col_act_i,
   input wire link_up_i,
   input wire full_duplex_i,
   output reg second_led_output_o
);
   // ------------------------------------------------------------
   // phy_led_control register
   // ------------------------------------------------------------
   reg [15:0] phy_led_control_q;
   wire [3:0] second_led_source_select;
   wire [1:0] stretch_sel;
   wire pulse_stretch_enable;

   always @(posedge clk_sys_i) begin
      if (srst_i) begin
         phy_led_control_q <= `PLEDB_RESET_VAL; // RL13
      end else if (reg_wr_i) begin
         // reserved bits are not stored, so bit 0 reads zero regardless
         phy_led_control_q <= reg_wdata_i & `PLEDB_WMASK; // RL12
      end
   end
   // reads show exactly what is stored, reserved bits as zero
   assign reg_rdata_o = phy_led_control_q;
   assign second_led_source_select =
      phy_led_control_q[`PLEDB_SRC_HI:`PLEDB_SRC_LO]; // RL1
   assign stretch_sel =
      phy_led_control_q[`PLEDB_TSEL_HI:`PLEDB_TSEL_LO]; // RL13
   assign pulse_stretch_enable = phy_led_control_q[`PLEDB_STREN_BIT];

   // ------------------------------------------------------------
   // stretch timers, one per event kind
   // ------------------------------------------------------------
   // reserved time code 11 falls back to the shortest time
   function [31:0] stretch_len;
      input [1:0] sel;
      begin
         case (sel)
            `PLEDB_TS_T1: stretch_len = T1_CYC;
            `PLEDB_TS_T2: stretch_len = T2_CYC;
            default: stretch_len = T0_CYC;
         endcase
      end
   endfunction

   // next value of a stretch count: reload on an event, else run down
   function [31:0] stretch_next;
      input event_seen;
      input [31:0] count;
      input [31:0] reload;
      begin
         if (event_seen) begin
            stretch_next = reload;
         end else if (count != 32'h0) begin
            stretch_next = count - 32'h1;
         end else begin
            stretch_next = 32'h0;
         end
      end
   endfunction

   reg [31:0] tx_cnt_q;
   reg [31:0] rx_cnt_q;
   reg [31:0] col_cnt_q;
   wire [31:0] len;
   wire [31:0] tx_cnt_d;
   wire [31:0] rx_cnt_d;
   wire [31:0] col_cnt_d;

   // a new time code takes effect at the next event, not mid-stretch
   assign len = stretch_len(stretch_sel); // RL13
   // an event reloads the count, so a burst keeps the led lit
   assign tx_cnt_d = stretch_next(tx_act_i, tx_cnt_q, len); // RL14
   assign rx_cnt_d = stretch_next(rx_act_i, rx_cnt_q, len); // RL14
   assign col_cnt_d = stretch_next(col_act_i, col_cnt_q, len); // RL14

   always @(posedge clk_sys_i) begin
      if (srst_i) begin
         tx_cnt_q <= 32'h0;
      end else begin
         tx_cnt_q <= tx_cnt_d;
      end
   end

   always @(posedge clk_sys_i) begin
      if (srst_i) begin
         rx_cnt_q <= 32'h0;
      end else begin
         rx_cnt_q <= rx_cnt_d;
      end
   end

   always @(posedge clk_sys_i) begin
      if (srst_i) begin
         col_cnt_q <= 32'h0;
      end else begin
         col_cnt_q <= col_cnt_d;
      end
   end

   // status modes use the stretched form whatever the enable bit says
   wire tx_s = tx_act_i | (tx_cnt_q != 32'h0);
   wire rx_s = rx_act_i | (rx_cnt_q != 32'h0);
   wire col_s = col_act_i | (col_cnt_q != 32'h0);
   wire tx_o = pulse_stretch_enable ? tx_s : tx_act_i;
   wire rx_o = pulse_stretch_enable ? rx_s : rx_act_i;
   wire col_o = pulse_stretch_enable ? col_s : col_act_i;

   // ------------------------------------------------------------
   // blink dividers
   // ------------------------------------------------------------
   reg [31:0] slow_cnt_q;
   reg [31:0] fast_cnt_q;
   reg slow_q;
   reg fast_q;
   wire slow_wrap;
   wire fast_wrap;

   // each phase lasts a whole count, so a period is twice the count
   assign slow_wrap = (slow_cnt_q >= SLOW_CYC - 32'h1);
   assign fast_wrap = (fast_cnt_q >= FAST_CYC - 32'h1);

   always @(posedge clk_sys_i) begin
      if (srst_i) begin
         slow_cnt_q <= 32'h0;
      end else if (slow_wrap) begin
         slow_cnt_q <= 32'h0;
      end else begin
         slow_cnt_q <= slow_cnt_q + 32'h1;
      end
   end

   always @(posedge clk_sys_i) begin
      if (srst_i) begin
         slow_q <= 1'b0;
      end else if (slow_wrap) begin
         slow_q <= ~slow_q; // RL5
      end
   end

   always @(posedge clk_sys_i) begin
      if (srst_i) begin
         fast_cnt_q <= 32'h0;
      end else if (fast_wrap) begin
         fast_cnt_q <= 32'h0;
      end else begin
         fast_cnt_q <= fast_cnt_q + 32'h1;
      end
   end

   always @(posedge clk_sys_i) begin
      if (srst_i) begin
         fast_q <= 1'b0;
      end else if (fast_wrap) begin
         fast_q <= ~fast_q;
      end
   end

   // ------------------------------------------------------------
   // source select
   // ------------------------------------------------------------
   reg led_d;
   always @* begin
      case (second_led_source_select)
         `PLEDB_C_TX: led_d = tx_o; // RL11
         `PLEDB_C_RX: led_d = rx_o; // RL10
         `PLEDB_C_COL: led_d = col_o; // RL9
         `PLEDB_C_LINK: led_d = link_up_i; // RL8
         `PLEDB_C_DUP: led_d = full_duplex_i; // RL7
         `PLEDB_C_TXRX: led_d = tx_o | rx_o; // RL6
         `PLEDB_C_ON: led_d = 1'b1; // RL5
         `PLEDB_C_OFF: led_d = 1'b0; // RL5
         `PLEDB_C_BSLOW: led_d = slow_q; // RL5
         `PLEDB_C_BFAST: led_d = fast_q;
         // link or duplex lit, inverted while stretched activity or collisions are seen
         `PLEDB_C_LNKRX: led_d = link_up_i ^ rx_s; // RL4
         `PLEDB_C_LNKTR: led_d = link_up_i ^ (tx_s | rx_s); // RL3
         `PLEDB_C_DUPCOL: led_d = full_duplex_i ^ col_s; // RL2
         `PLEDB_C_RSV0: led_d = 1'b0; // RL1
         `PLEDB_C_RSV6: led_d = 1'b0; // RL1
         default: led_d = 1'b0; // RL1
      endcase
   end

   // the pin comes from a flop so a change of source cannot glitch it
   always @(posedge clk_sys_i) begin
      if (srst_i) begin
         second_led_output_o <= 1'b0;
      end else begin
         second_led_output_o <= led_d;
      end
   end
endmodule

// ===== pkg/pledb_consts.vh
`ifndef PLEDB_CONSTS_VH
`define PLEDB_CONSTS_VH
// ------------------------------------------------------------
// register layout
// ------------------------------------------------------------
`define PLEDB_REG_W 16
`define PLEDB_RESET_VAL 16'h0002
`define PLEDB_WMASK 16'h00FE
`define PLEDB_SRC_HI 7
`define PLEDB_SRC_LO 4
`define PLEDB_TSEL_HI 3
`define PLEDB_TSEL_LO 2
`define PLEDB_STREN_BIT 1
`define PLEDB_TS_T1 2'h1
`define PLEDB_TS_T2 2'h2
// ------------------------------------------------------------
// source select codes
// ------------------------------------------------------------
`define PLEDB_C_RSV0 4'h0
`define PLEDB_C_TX 4'h1
`define PLEDB_C_RX 4'h2
`define PLEDB_C_COL 4'h3
`define PLEDB_C_LINK 4'h4
`define PLEDB_C_DUP 4'h5
`define PLEDB_C_RSV6 4'h6
`define PLEDB_C_TXRX 4'h7
`define PLEDB_C_ON 4'h8
`define PLEDB_C_OFF 4'h9
`define PLEDB_C_BFAST 4'hA
`define PLEDB_C_BSLOW 4'hB
`define PLEDB_C_LNKRX 4'hC
`define PLEDB_C_LNKTR 4'hD
`define PLEDB_C_DUPCOL 4'hE
// ------------------------------------------------------------
// timing, in nanoseconds and cycles at 125 MHz
// ------------------------------------------------------------
`define PLEDB_CLK_NS 8
`define PLEDB_T0_NS 40000000
`define PLEDB_T1_NS 70000000
`define PLEDB_T2_NS 140000000
`define PLEDB_SLOW_NS 1000000000
`define PLEDB_FAST_NS 250000000
`define PLEDB_CYC(ns) ((ns) / `PLEDB_CLK_NS)
`endif

// ===== testbench/pledb_led_model.sv
`timescale 1ns/1ps
// the indicator pin: counts lit cycles so stretch length can be judged
module pledb_led_model (
   input wire logic clk_sys_i,
   input wire logic clr_i,
   input wire logic led_i,
   output int on_cyc_o
);
   always @(posedge clk_sys_i) begin
      if (clr_i) on_cyc_o <= 0;
      else if (led_i) on_cyc_o <= on_cyc_o + 1;
   end
endmodule

// ===== testbench/pledb_chk.sv
`timescale 1ns/1ps
module pledb_chk (
   input wire logic clk_sys_i,
   input wire logic srst_i,
   input wire logic reg_wr_i,
   input wire logic [15:0] reg_wdata_i,
   input wire logic [15:0] reg_rdata_o,
   input wire logic tx_act_i,
   input wire logic rx_act_i,
   input wire logic col_act_i,
   input wire logic link_up_i,
   input wire logic full_duplex_i,
   input wire logic second_led_output_o
);
   wire [3:0] c = reg_rdata_o[7:4];
   wire led = second_led_output_o;
   wire str = reg_rdata_o[1];
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (srst_i);
   sequence s_lit3; led [*3]; endsequence
   // reset must be checked while it is asserted, so no disable here
   property p_rst; disable iff (1'b0)
      srst_i |=> reg_rdata_o == 16'h0002 && !led; endproperty
   a_rst: assert property (p_rst) else $error("reset value");
   property p_wr;
      reg_wr_i |=> reg_rdata_o == ($past(reg_wdata_i) & 16'h00FE); endproperty
   a_wr: assert property (p_wr) else $error("write");
   property p_on; c == 4'h8 |=> led; endproperty
   a_on: assert property (p_on) else $error("on");
   property p_off; c inside {4'h0, 4'h6, 4'h9} |=> !led; endproperty
   a_off: assert property (p_off) else $error("off");
   property p_link; c == 4'h4 |=> led == $past(link_up_i); endproperty
   a_link: assert property (p_link) else $error("link");
   property p_dup; c == 4'h5 |=> led == $past(full_duplex_i); endproperty
   a_dup: assert property (p_dup) else $error("duplex");
   property p_act; (c == 4'h1 && tx_act_i) || (c == 4'h2 && rx_act_i) ||
      (c == 4'h3 && col_act_i) || (c == 4'h7 && (tx_act_i || rx_act_i))
      |=> led; endproperty
   a_act: assert property (p_act) else $error("activity");
   property p_str; c == 4'h1 && str && tx_act_i |=> s_lit3; endproperty
   a_str: assert property (p_str) else $error("stretch");
   property p_nostr; c == 4'h1 && !str && !tx_act_i |=> !led; endproperty
   a_nostr: assert property (p_nostr) else $error("no stretch");
endmodule
bind pledb_led_ctrl pledb_chk i_chk (.*);

// ===== testbench/phy_led_b_control_bench.sv
`timescale 1ns/1ps
module phy_led_b_control_bench;
   reg clk_sys_i = 0, srst_i = 1, reg_wr_i = 0, clr = 1;
   reg tx_act_i = 0, rx_act_i = 0, col_act_i = 0;
   reg link_up_i = 0, full_duplex_i = 0;
   reg [15:0] reg_wdata_i = 16'h0000;
   wire [15:0] reg_rdata_o;
   wire second_led_output_o;
   int n_fail = 0, compares = 0, lit;
   initial forever #4 clk_sys_i = ~clk_sys_i;
   // short stretch and blink counts keep the run brief
   pledb_led_ctrl #(.T0_CYC(8), .T1_CYC(12), .T2_CYC(16), .SLOW_CYC(6),
      .FAST_CYC(4)) i_dut (.*);
   pledb_led_model i_led (.clk_sys_i, .clr_i(clr),
      .led_i(second_led_output_o), .on_cyc_o(lit));
   task cyc(input int n); repeat (n) @(negedge clk_sys_i); endtask
   task cmp(input logic [15:0] a, input logic [15:0] e);
      compares++;
      if (a !== e) begin
         n_fail++;
         $display("CHECK FAILED %0t got %h exp %h", $time, a, e);
      end
   endtask
   task wr(input logic [15:0] d);
      reg_wdata_i = d;
      reg_wr_i = 1;
      cyc(1);
      reg_wr_i = 0;
      cyc(2);
   endtask
   task t_reg;
      cmp(reg_rdata_o, 16'h0002);
      cmp(second_led_output_o, 16'h0000);
      wr(16'hFFFE);
      cmp(reg_rdata_o, 16'h00FE);
      cmp(second_led_output_o, 16'h0000);
   endtask
   task automatic t_static;
      logic [35:0] codes = 36'h890645CDE;
      logic [17:0] exp = {9'b100010110, 9'b100001001};
      for (int i = 0; i < 18; i++) begin
         link_up_i = i < 9;
         full_duplex_i = i >= 9;
         wr({8'h00, codes[35 - 4 * (i % 9) -: 4], 4'h0});
         cmp(second_led_output_o, exp[17 - i]);
      end
   endtask
   task automatic t_act;
      logic [15:0] ac = 16'h1237;
      logic [11:0] am = 12'b001_010_100_010;
      for (int k = 0; k < 4; k++) begin
         wr({8'h00, ac[15 - 4 * k -: 4], 4'h0});
         {col_act_i, rx_act_i, tx_act_i} = am[11 - 3 * k -: 3];
         cyc(1);
         cmp(second_led_output_o, 16'h0001);
         {col_act_i, rx_act_i, tx_act_i} = 3'b000;
         cyc(1);
         cmp(second_led_output_o, 16'h0000);
      end
   endtask
   task t_str;
      wr(16'h0012);
      clr = 0;
      for (int k = 0; k < 2; k++) begin
         tx_act_i = 1;
         cyc(1);
         tx_act_i = 0;
         cyc(3);
      end
      cyc(20);
      cmp(lit, 16'h000D);
   endtask
   task t_blink;
      wr(16'h00B0);
      clr = 1;
      cyc(1);
      clr = 0;
      cyc(12);
      cmp(lit, 16'h0006);
      wr(16'h00A0);
      clr = 1;
      cyc(1);
      clr = 0;
      cyc(8);
      cmp(lit, 16'h0004);
   endtask
   task automatic t_comb;
      logic [11:0] cc = 12'hCDE;
      logic [8:0] ev = 9'b010_001_100;
      for (int k = 0; k < 3; k++) begin
         link_up_i = 1;
         full_duplex_i = 1;
         wr({8'h00, cc[11 - 4 * k -: 4], 4'h0});
         clr = 1;
         cyc(1);
         clr = 0;
         {col_act_i, rx_act_i, tx_act_i} = ev[8 - 3 * k -: 3];
         cyc(1);
         {col_act_i, rx_act_i, tx_act_i} = 3'b000;
         cyc(19);
         cmp(lit, 16'h000B);
      end
   endtask
   task final_report;
      if (n_fail == 0 && compares > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      cyc(5);
      srst_i = 0;
      cyc(1);
      t_reg;
      t_static;
      t_act;
      t_str;
      t_blink;
      t_comb;
      final_report;
   end
endmodule
